// ===== jss_sequencer.sv
`timescale 1ns/100ps
module jss_sequencer #(
  parameter int unsigned NUM_SETS = jss_pkg::N_SETS
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Terminal pins
  input wire logic jog_positive_signal_i,
  input wire logic jog_negative_signal_i,
  input wire logic [jss_pkg::SEL_W-1:0] set_select_weight_i,
  input wire logic set_release_input_i,
  input wire logic next_start_input_i,
  input wire logic halt_input_i,
  // Motion loop status
  input wire logic axis_standstill_i,
  input wire logic pos_done_i,
  input wire logic start_cond_i,
  // Motion loop commands
  output logic jog_active_o,
  output logic speed_ctrl_o,
  output logic [31:0] jog_speed_o,
  output logic jog_dir_neg_o,
  output logic task_start_o,
  output logic [jss_pkg::SEL_W-1:0] executing_set_number_o,
  output logic task_rel_o,
  output logic halt_o,
  output logic quick_stop_o,
  output logic [jss_pkg::SLIP_W-1:0] slip_ms_o,
  output logic [jss_pkg::SEL_W-1:0] set_num_pins_o
);
  import jss_pkg::*;

  if (NUM_SETS != N_SETS) begin : g_chk
    $error("NUM_SETS must be 16");
  end

  function automatic logic is_tab(input logic [7:0] a);
    return a[7:6] == OFS_TAB[7:6];
  endfunction

  function automatic logic [SEL_W-1:0] tab_idx(input logic [7:0] a);
    return a[5:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and trigger edges
  logic [8:0] sy1_q, sy2_q;
  logic [1:0] trg_q;
  logic [8:0] pins;
  logic rel_pin_ev, nxt_pin_ev;

  always_comb begin
    pins = {halt_input_i, next_start_input_i, set_release_input_i,
            set_select_weight_i, jog_negative_signal_i,
            jog_positive_signal_i};
    rel_pin_ev = sy2_q[6] & ~trg_q[0];
    nxt_pin_ev = sy2_q[7] & ~trg_q[1];
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_q <= 9'h000;
      sy2_q <= 9'h000;
      trg_q <= 2'h0;
    end else if (ce_i) begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
      trg_q <= sy2_q[7:6];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and register file
  logic wr_q, wr_d, rd_q, rd_d, hready_q, hready_d;
  logic [7:0] adr_q, adr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [SEL_W-1:0] bsel_q, bsel_d;
  logic [31:0] qjog_q, qjog_d, sjog_q, sjog_d;
  logic [SLIP_W-1:0] slip_q, slip_d;
  logic [TAB_W-1:0] tab_q [N_SETS];
  logic [TAB_W-1:0] tab_d [N_SETS];
  logic bus_rel_q, bus_rel_d, bus_nxt_q, bus_nxt_d;
  logic [31:0] stat;
  logic ap_ok;
  jss_jog_e jog_q, jog_d;
  jss_seq_e seq_q, seq_d;
  logic [SEL_W-1:0] cur_q, cur_d, sel_now;

  always_comb begin
    ap_ok = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
    wr_d = ap_ok & hwrite_i & (hsize_i == HSIZE_WORD);
    rd_d = ap_ok & ~hwrite_i;
    adr_d = ap_ok ? haddr_i[7:0] : adr_q;
    hready_d = ~rd_d;
    ctrl_d = ctrl_q;
    bsel_d = bsel_q;
    qjog_d = qjog_q;
    sjog_d = sjog_q;
    slip_d = slip_q;
    tab_d = tab_q;
    bus_rel_d = 1'b0;
    bus_nxt_d = 1'b0;
    stat = 32'h0000_0000;
    stat[SEL_W-1:0] = cur_q;
    stat[SB_SEL +: SEL_W] = sel_now;
    stat[SB_RUN] = seq_q == S_RUN;
    stat[SB_WAIT] = seq_q == S_WAIT;
    stat[SB_JOG] = jog_q != J_OFF;
    stat[SB_RAPID] = jog_q == J_RAPID;
    hrdata_d = hrdata_q;
    if (rd_q) begin
      hrdata_d = 32'h0000_0000;
      if (is_tab(adr_q)) begin
        hrdata_d[TAB_W-1:0] = tab_q[tab_idx(adr_q)];
      end else begin
        case ({adr_q[7:2], 2'b00})
          OFS_CTRL: hrdata_d[CTRL_W-1:0] = ctrl_q;
          OFS_SEL: hrdata_d[SEL_W-1:0] = bsel_q;
          OFS_QJOG: hrdata_d = qjog_q;
          OFS_SJOG: hrdata_d = sjog_q;
          OFS_SLIP: hrdata_d[SLIP_W-1:0] = slip_q;
          OFS_STAT: hrdata_d = stat;
          default: hrdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (wr_q) begin
      if (is_tab(adr_q)) begin
        tab_d[tab_idx(adr_q)] = hwdata_i[TAB_W-1:0];
      end else begin
        case ({adr_q[7:2], 2'b00})
          OFS_CTRL: begin
            ctrl_d = hwdata_i[CTRL_W-1:0];
            ctrl_d[CB_REL] = 1'b0;
            ctrl_d[CB_NXT] = 1'b0;
            bus_rel_d = hwdata_i[CB_REL];
            bus_nxt_d = hwdata_i[CB_NXT];
          end
          OFS_SEL: bsel_d = hwdata_i[SEL_W-1:0];
          OFS_QJOG: qjog_d = hwdata_i;
          OFS_SJOG: sjog_d = hwdata_i;
          OFS_SLIP: slip_d = hwdata_i[SLIP_W-1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 8'h00;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RST;
      bsel_q <= 4'h0;
      qjog_q <= QJOG_RST;
      sjog_q <= SJOG_RST;
      slip_q <= SLIP_RST;
      bus_rel_q <= 1'b0;
      bus_nxt_q <= 1'b0;
      for (int i = 0; i < N_SETS; i++) begin
        tab_q[i] <= TAB_RST;
      end
    end else if (ce_i) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      adr_q <= adr_d;
      hready_q <= hready_d;
      hrdata_q <= hrdata_d;
      ctrl_q <= ctrl_d;
      bsel_q <= bsel_d;
      qjog_q <= qjog_d;
      sjog_q <= sjog_d;
      slip_q <= slip_d;
      bus_rel_q <= bus_rel_d;
      bus_nxt_q <= bus_nxt_d;
      tab_q <= tab_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Jog state machine
  logic dir_q, dir_d, blk_q, blk_d;
  logic jp, jn, first, second, ena;
  logic seq_busy;

  always_comb begin
    ena = ctrl_q[CB_ENA];
    jp = sy2_q[0] | ctrl_q[CB_JP];
    jn = sy2_q[1] | ctrl_q[CB_JN];
    first = dir_q ? jn : jp;
    second = dir_q ? jp : jn;
    jog_d = jog_q;
    dir_d = dir_q;
    blk_d = blk_q;
    case (jog_q)
      J_OFF: begin
        if (ena && !seq_busy && axis_standstill_i && (jp ^ jn)) begin
          jog_d = J_CREEP;
          dir_d = jn;
          blk_d = 1'b0;
        end
      end
      J_CREEP: begin
        if (!second) begin
          blk_d = 1'b0;
        end
        if (!first) begin
          jog_d = J_OFF;
        end else if (second && !blk_q) begin
          jog_d = J_RAPID;
        end
      end
      J_RAPID: begin
        if (!first) begin
          jog_d = J_STOP;
          blk_d = 1'b1;
        end else if (!second) begin
          jog_d = J_CREEP;
        end
      end
      J_STOP: begin
        if (!second) begin
          blk_d = 1'b0;
        end
        if (first) begin
          jog_d = J_CREEP;
        end else if (!second) begin
          jog_d = J_OFF;
        end
      end
      default: jog_d = J_OFF;
    endcase
    if (!ena) begin
      jog_d = J_OFF;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      jog_q <= J_OFF;
      dir_q <= 1'b0;
      blk_q <= 1'b0;
    end else if (ce_i) begin
      jog_q <= jog_d;
      dir_q <= dir_d;
      blk_q <= blk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Driving set sequencer
  logic [7:0] rep_q, rep_d;
  logic prep_q, prep_d, start_q, start_d;
  logic rel_ev, nxt_ev, start_new, adv;
  logic [TAB_W-1:0] cur_ent, sel_ent, fol_ent;
  logic [4:0] fol;

  always_comb begin
    seq_busy = seq_q != S_IDLE;
    sel_now = ctrl_q[CB_BSEL] ? bsel_q : sy2_q[5:2];
    rel_ev = rel_pin_ev | bus_rel_q;
    nxt_ev = nxt_pin_ev | bus_nxt_q;
    start_new = (rel_ev | (nxt_ev & (seq_q != S_WAIT))) &
                ena & (jog_q == J_OFF);
    adv = nxt_ev | start_cond_i;
    cur_ent = tab_q[cur_q];
    sel_ent = tab_q[sel_now];
    fol = cur_ent[TF_FOL +: 5];
    fol_ent = tab_q[fol[3:0]];
    seq_d = seq_q;
    cur_d = cur_q;
    rep_d = rep_q;
    prep_d = prep_q;
    start_d = 1'b0;
    if (start_new) begin
      seq_d = S_RUN;
      cur_d = sel_now;
      rep_d = sel_ent[TF_REP +: 8];
      start_d = 1'b1;
    end else begin
      case (seq_q)
        S_RUN: begin
          if (pos_done_i) begin
            if (cur_ent[TF_REL] && rep_q != 8'h00) begin
              seq_d = S_WAIT;
              prep_d = 1'b1;
            end else if (!fol[4]) begin
              seq_d = S_WAIT;
              prep_d = 1'b0;
            end else begin
              seq_d = S_IDLE;
            end
          end
        end
        S_WAIT: begin
          if (adv && ena) begin
            seq_d = S_RUN;
            start_d = 1'b1;
            if (prep_q) begin
              rep_d = rep_q - 8'h01;
            end else begin
              cur_d = fol[3:0];
              rep_d = fol_ent[TF_REP +: 8];
            end
          end
        end
        default: seq_d = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_q <= S_IDLE;
      cur_q <= 4'h0;
      rep_q <= 8'h00;
      prep_q <= 1'b0;
      start_q <= 1'b0;
    end else if (ce_i) begin
      seq_q <= seq_d;
      cur_q <= cur_d;
      rep_q <= rep_d;
      prep_q <= prep_d;
      start_q <= start_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      jog_active_o <= 1'b0;
      speed_ctrl_o <= 1'b0;
      jog_speed_o <= 32'h0000_0000;
      jog_dir_neg_o <= 1'b0;
      executing_set_number_o <= 4'h0;
      task_rel_o <= 1'b0;
      halt_o <= 1'b0;
      quick_stop_o <= 1'b0;
      slip_ms_o <= SLIP_RST;
      set_num_pins_o <= 4'h0;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      jog_active_o <= jog_q != J_OFF;
      speed_ctrl_o <= jog_q != J_OFF;
      jog_speed_o <= (jog_q == J_RAPID) ? qjog_q :
                     (jog_q == J_CREEP) ? sjog_q : 32'h0000_0000;
      jog_dir_neg_o <= dir_q;
      executing_set_number_o <= cur_q;
      task_rel_o <= cur_ent[TF_REL];
      halt_o <= ena & (ctrl_q[CB_HALT] | sy2_q[8]);
      quick_stop_o <= ctrl_q[CB_QSTP];
      slip_ms_o <= slip_q;
      set_num_pins_o <= ctrl_q[CB_OUTE] ? cur_q : 4'h0;
      hresp_o <= 1'b0;
    end
  end

  assign task_start_o = start_q;
  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk_i iff ce_i); endclocking
  default disable iff (rst_i);

  sequence s_rapid_drop;
    jog_q == J_RAPID && !first;
  endsequence
  sequence s_stopped;
    jog_q == J_STOP ##1 jog_speed_o == 32'h0000_0000;
  endsequence

  AST_JOG_ENTRY: assert property (
    (jog_q != J_OFF && $past(jog_q) == J_OFF) |-> $past(axis_standstill_i))
    else $error("jog entered while axis moving");
  AST_SPEED_MODE: assert property (
    jog_q != J_OFF |=> speed_ctrl_o && jog_active_o)
    else $error("jog not speed controlled");
  AST_CREEP: assert property (
    jog_q == J_CREEP |=> jog_speed_o == $past(sjog_q))
    else $error("creep speed wrong");
  AST_RAPID: assert property (
    (jog_q == J_CREEP && second && !blk_q && first && ena)
    |=> jog_q == J_RAPID ##1 jog_speed_o == $past(qjog_q))
    else $error("rapid not taken");
  AST_RAPID_STOP: assert property (
    s_rapid_drop ##0 ena |=> s_stopped)
    else $error("rapid not stopped");
  AST_NO_STALE_RAPID: assert property (
    (jog_q == J_CREEP && blk_q) |=> jog_q != J_RAPID)
    else $error("rapid without fresh request");
  AST_RELEASE: assert property (
    (rel_ev && start_new) |=> seq_q == S_RUN && cur_q == $past(sel_now)
    ##1 executing_set_number_o == $past(cur_q))
    else $error("release did not start selected set");
  AST_NEXT_START: assert property (
    (nxt_ev && start_new && !rel_ev) |=> task_start_o && cur_q == $past(sel_now))
    else $error("next start did not act as release");
  AST_REPEAT_FIRST: assert property (
    (seq_q == S_RUN && pos_done_i && !start_new && cur_ent[TF_REL]
     && rep_q != 8'h00) |=> seq_q == S_WAIT && prep_q)
    else $error("follow-up taken before repetitions");
  AST_NO_FOLLOW: assert property (
    (seq_q == S_RUN && pos_done_i && !start_new && fol[4]
     && !(cur_ent[TF_REL] && rep_q != 8'h00)) |=> seq_q == S_IDLE)
    else $error("follow-up run after minus one");
  AST_EDGE_ONLY: assert property (
    rel_pin_ev |=> !rel_pin_ev)
    else $error("held release retriggered");
endmodule

// ===== jss_pkg.sv
package jss_pkg;
  localparam int unsigned N_SETS = 16;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned SLIP_W = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_QJOG = 8'h08;
  localparam logic [7:0] OFS_SJOG = 8'h0C;
  localparam logic [7:0] OFS_SLIP = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_TAB = 8'h40;
  // Control register bits
  localparam int unsigned CB_ENA = 0;
  localparam int unsigned CB_REL = 1;
  localparam int unsigned CB_NXT = 2;
  localparam int unsigned CB_HALT = 3;
  localparam int unsigned CB_QSTP = 4;
  localparam int unsigned CB_JP = 5;
  localparam int unsigned CB_JN = 6;
  localparam int unsigned CB_BSEL = 7;
  localparam int unsigned CB_OUTE = 8;
  localparam int unsigned CTRL_W = 9;
  // Table entry fields
  localparam int unsigned TF_REP = 0;
  localparam int unsigned TF_FOL = 8;
  localparam int unsigned TF_REL = 13;
  localparam int unsigned TAB_W = 14;
  localparam logic [4:0] FOLLOW_NONE = 5'h1F;
  // Status register bits
  localparam int unsigned SB_SEL = 4;
  localparam int unsigned SB_RUN = 8;
  localparam int unsigned SB_WAIT = 9;
  localparam int unsigned SB_JOG = 10;
  localparam int unsigned SB_RAPID = 11;
  // Reset values, bus encodings and state types
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [31:0] QJOG_RST = 32'h0000_03E8;
  localparam logic [31:0] SJOG_RST = 32'h0000_01F4;
  localparam logic [SLIP_W-1:0] SLIP_RST = 16'h0000;
  localparam logic [TAB_W-1:0] TAB_RST = 14'h1F00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {J_OFF, J_CREEP, J_RAPID, J_STOP} jss_jog_e;
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} jss_seq_e;
endpackage

// ===== jss_plc_model.sv
`timescale 1ns/100ps
module jss_plc_model (
  // Clock
  input wire logic ref_clk_i,
  // Terminal pins
  output logic jog_p_o,
  output logic jog_n_o,
  output logic [jss_pkg::SEL_W-1:0] sel_o,
  output logic rel_o,
  output logic nxt_o,
  output logic halt_o
);
  initial begin
    jog_p_o = 1'b0;
    jog_n_o = 1'b0;
    sel_o = '0;
    rel_o = 1'b0;
    nxt_o = 1'b0;
    halt_o = 1'b0;
  end
  // Caller keeps the axis stopped before jog entry
  task automatic jog(input logic p, input logic n);
    @(posedge ref_clk_i);
    jog_p_o <= p;
    jog_n_o <= n;
  endtask
  // Selection settles before the trigger rises
  task automatic start(input logic [3:0] s, input logic nx, input int hold);
    @(posedge ref_clk_i);
    sel_o <= s;
    repeat (3) @(posedge ref_clk_i);
    if (nx) nxt_o <= 1'b1;
    else rel_o <= 1'b1;
    repeat (hold) @(posedge ref_clk_i);
    rel_o <= 1'b0;
    nxt_o <= 1'b0;
  endtask
  task automatic halt(input logic h);
    @(posedge ref_clk_i);
    halt_o <= h;
  endtask
endmodule

// ===== jog_and_driving_set_sequencer_tb.sv
`timescale 1ns/100ps
module jog_and_driving_set_sequencer_tb;
  import jss_pkg::*;
  logic ref_clk_i, rst_i, ce_i, hsel_i, hwrite_i, stand_i, done_i, cond_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, jog_speed_o, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic hreadyout_o, hresp_o, jog_active_o, speed_ctrl_o, jog_dir_neg_o;
  logic task_start_o, task_rel_o, halt_o, quick_stop_o;
  logic jp, jn, rel, nxt, hlt;
  logic [3:0] sel, exec_o, pins_o;
  logic [15:0] slip_o;
  int num_errors = 0, check_count = 0, cycles = 0, n_starts = 0, n0;
  jss_plc_model u_jss_plc_model (.ref_clk_i(ref_clk_i), .jog_p_o(jp),
    .jog_n_o(jn), .sel_o(sel), .rel_o(rel), .nxt_o(nxt), .halt_o(hlt));
  jss_sequencer u_jss_sequencer (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .jog_positive_signal_i(jp),
    .jog_negative_signal_i(jn), .set_select_weight_i(sel),
    .set_release_input_i(rel), .next_start_input_i(nxt),
    .halt_input_i(hlt), .axis_standstill_i(stand_i), .pos_done_i(done_i),
    .start_cond_i(cond_i), .jog_active_o(jog_active_o),
    .speed_ctrl_o(speed_ctrl_o), .jog_speed_o(jog_speed_o),
    .jog_dir_neg_o(jog_dir_neg_o), .task_start_o(task_start_o),
    .executing_set_number_o(exec_o), .task_rel_o(task_rel_o),
    .halt_o(halt_o), .quick_stop_o(quick_stop_o), .slip_ms_o(slip_o),
    .set_num_pins_o(pins_o));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= HTRANS_NONSEQ;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= w;
    hsize_i <= HSIZE_WORD;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    rd = hrdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
    chk({31'h0, hresp_o}, 32'h0);
  endtask
  task automatic wait_speed(input logic [31:0] e);
    for (int i = 0; i < 12 && jog_speed_o !== e; i++) @(posedge ref_clk_i);
    repeat (3) @(posedge ref_clk_i);
    chk(jog_speed_o, e);
  endtask
  task automatic wait_start(input logic [3:0] e);
    for (int i = 0; i < 16 && task_start_o !== 1'b1; i++)
      @(posedge ref_clk_i);
    chk({31'h0, task_start_o}, 32'h1);
    @(posedge ref_clk_i);
    chk({31'h0, task_start_o}, 32'h0);
    chk({24'h00_0000, exec_o, pins_o}, {24'h00_0000, e, e});
  endtask
  task automatic loop_pulse(input logic d);
    @(posedge ref_clk_i);
    if (d) done_i <= 1'b1;
    else cond_i <= 1'b1;
    @(posedge ref_clk_i);
    done_i <= 1'b0;
    cond_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    rchk(OFS_QJOG, 32'h0000_03E8);
    rchk(OFS_SJOG, 32'h0000_01F4);
    rchk(OFS_TAB + 8'h3C, 32'h0000_1F00);
    rchk(8'h30, 32'h0000_0000);
    ahb(1'b1, OFS_SLIP, 32'h0000_0032);
    // Register lands, output follows one edge later
    repeat (2) @(posedge ref_clk_i);
    chk({16'h0000, slip_o}, 32'h0000_0032);
    ahb(1'b1, OFS_CTRL, 32'h0000_0101);
  endtask
  task automatic test_jog;
    logic [1:0] pat [9] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3,
                            2'h2, 2'h0};
    logic [31:0] sp [9] = '{0, 500, 1000, 0, 500, 500, 1000, 500, 0};
    for (int i = 0; i < 9; i++) begin
      u_jss_plc_model.jog(pat[i][1], pat[i][0]);
      wait_speed(sp[i]);
      if (i == 1) chk({30'h0, speed_ctrl_o, jog_dir_neg_o}, 32'h2);
      stand_i <= (sp[i] == 0);
    end
    u_jss_plc_model.jog(1'b0, 1'b1);
    wait_speed(32'd500);
    chk({31'h0, jog_dir_neg_o}, 32'h1);
    u_jss_plc_model.jog(1'b0, 1'b0);
    wait_speed(32'd0);
    stand_i <= 1'b0;
    u_jss_plc_model.jog(1'b1, 1'b0);
    repeat (8) @(posedge ref_clk_i);
    chk({31'h0, jog_active_o}, 32'h0);
    u_jss_plc_model.jog(1'b0, 1'b0);
    stand_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    ahb(1'b1, OFS_CTRL, 32'h0000_0121);
    wait_speed(32'd500);
    ahb(1'b1, OFS_CTRL, 32'h0000_0101);
    wait_speed(32'd0);
  endtask
  task automatic run(input logic [3:0] s, input logic nx, input logic [3:0] e);
    fork
      u_jss_plc_model.start(s, nx, 1);
      wait_start(e);
    join
  endtask
  task automatic test_seq;
    ahb(1'b1, OFS_TAB + 8'h08, 32'h0000_2301);
    run(4'h2, 1'b0, 4'h2);
    chk({31'h0, task_rel_o}, 32'h1);
    rchk(OFS_STAT, 32'h0000_0122);
    loop_pulse(1'b1);
    fork
      loop_pulse(1'b0);
      wait_start(4'h2);
    join
    loop_pulse(1'b1);
    run(4'h2, 1'b1, 4'h3);
    loop_pulse(1'b1);
    rchk(OFS_STAT, 32'h0000_0023);
    run(4'h6, 1'b1, 4'h6);
    chk({31'h0, task_rel_o}, 32'h0);
    loop_pulse(1'b1);
    run(4'h2, 1'b0, 4'h2);
    loop_pulse(1'b1);
    run(4'h5, 1'b0, 4'h5);
    loop_pulse(1'b1);
    n0 = n_starts;
    loop_pulse(1'b0);
    chk(n_starts, n0);
    fork
      u_jss_plc_model.start(4'hF, 1'b0, 20);
      wait_start(4'hF);
    join
    chk(n_starts, n0 + 1);
    loop_pulse(1'b1);
    // Bus selection and bus release trigger
    ahb(1'b1, OFS_SEL, 32'h0000_0004);
    ahb(1'b1, OFS_CTRL, 32'h0000_0183);
    wait_start(4'h4);
    rchk(OFS_CTRL, 32'h0000_0181);
    loop_pulse(1'b1);
  endtask
  task automatic test_halt;
    u_jss_plc_model.halt(1'b1);
    repeat (5) @(posedge ref_clk_i);
    chk({31'h0, halt_o}, 32'h1);
    u_jss_plc_model.halt(1'b0);
    repeat (5) @(posedge ref_clk_i);
    chk({31'h0, halt_o}, 32'h0);
    // Frozen block must not see the halt pin
    ce_i <= 1'b0;
    u_jss_plc_model.halt(1'b1);
    repeat (5) @(posedge ref_clk_i);
    chk({31'h0, halt_o}, 32'h0);
    ce_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    chk({31'h0, halt_o}, 32'h1);
    u_jss_plc_model.halt(1'b0);
    ahb(1'b1, OFS_CTRL, 32'h0000_0119);
    repeat (2) @(posedge ref_clk_i);
    chk({30'h0, quick_stop_o, halt_o}, 32'h3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    if (task_start_o === 1'b1) n_starts <= n_starts + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    {hsel_i, hwrite_i, htrans_i, hsize_i} = '0;
    haddr_i = 32'h0000_0000;
    hwdata_i = 32'h0000_0000;
    {stand_i, done_i, cond_i} = 3'h4;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_jog();
    test_seq();
    test_halt();
    end_sim();
  end
endmodule
